/* logic/sefb_pkg.sv */
// Package for the SPI controller with its enable, disable and mode-fault behaviour.
// Assumes a single 50 MHz clock domain and plain control ports with no register bus.
package sefb_pkg;
  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned SEFB_DATA_W    = 8;
  localparam int unsigned SEFB_DIV_W     = 8;
  localparam logic [7:0]  SEFB_DIV_RST   = 8'h04;
  localparam logic        SEFB_TXE_RST   = 1'b1;
  localparam logic        SEFB_EN_RST    = 1'b0;

  typedef struct packed {
    logic master;
    logic cs_hold_after_transfer;
    logic mode_fault_disable;
    logic cpol;
  } sefb_cfg_t;

  typedef enum logic [2:0] {
    SEFB_IDLE = 3'b001,
    SEFB_SHIFT = 3'b010,
    SEFB_DONE = 3'b100
  } sefb_state_t;
endpackage : sefb_pkg

/* logic/sefb_spi.sv */
// SPI controller core: enable/disable, mode fault gate, tx empty flag, master or slave.
// Assumes config is static during a transfer and pins are asynchronous to clk_i.
`timescale 1ns/1ps
module sefb_spi
  import sefb_pkg::*;
#(
  parameter int unsigned DATA_W = SEFB_DATA_W
) (
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire sefb_cfg_t         cfg_i,
  input  wire logic [7:0]        clk_div_i,
  input  wire logic              enable_cmd_i,
  input  wire logic              disable_cmd_i,
  input  wire logic              soft_reset_bit_i,
  input  wire logic              tx_wr_i,
  input  wire logic [DATA_W-1:0] tx_data_reg_i,
  input  wire logic              rx_rd_i,
  input  wire logic              miso_i,
  input  wire logic              mosi_i,
  input  wire logic              sck_i,
  input  wire logic              ncs_i,
  output logic                   enabled_o,
  output logic                   tx_empty_flag_o,
  output logic                   rx_full_o,
  output logic [DATA_W-1:0]      rx_data_o,
  output logic                   busy_o,
  output logic                   sck_o,
  output logic                   mosi_o,
  output logic                   miso_o,
  output logic                   miso_oe_n_o,
  output logic                   ncs0_o
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sck_s, mosi_s, miso_s, ncs_s;
  sefb_sync u_sck  (.clk_i(clk_i), .reset_n_i(reset_n_i), .pin_i(sck_i),
                    .rst_val_i(cfg_i.cpol), .level_o(sck_s));
  sefb_sync u_mosi (.clk_i(clk_i), .reset_n_i(reset_n_i), .pin_i(mosi_i),
                    .rst_val_i(1'b0), .level_o(mosi_s));
  sefb_sync u_miso (.clk_i(clk_i), .reset_n_i(reset_n_i), .pin_i(miso_i),
                    .rst_val_i(1'b0), .level_o(miso_s));
  sefb_sync u_ncs  (.clk_i(clk_i), .reset_n_i(reset_n_i), .pin_i(ncs_i),
                    .rst_val_i(1'b1), .level_o(ncs_s));

  // ----------------------------------------------------------------
  // Enable
  // ----------------------------------------------------------------
  logic en_ff;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en_ff <= SEFB_EN_RST;
    end else if (soft_reset_bit_i) begin
      en_ff <= SEFB_EN_RST;
    end else if (enable_cmd_i) begin
      en_ff <= 1'b1;
    end else if (disable_cmd_i && cfg_i.master) begin
      en_ff <= 1'b0;
    end
  end

  // Writes while disabled are filtered, including late DMA words
  logic wr_ok;
  assign wr_ok = tx_wr_i && en_ff;

  // ----------------------------------------------------------------
  // Transmit holding register and empty flag
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] hold_ff;
  logic              txe_ff;
  logic              load;
  sefb_state_t       st_ff;
  logic              fault_block;

  // Hardware erratum kept: held cs0 with fault detection on never starts
  assign fault_block = cfg_i.master && cfg_i.cs_hold_after_transfer
                       && !cfg_i.mode_fault_disable;
  assign load = en_ff && !txe_ff && (st_ff == SEFB_IDLE) && !fault_block
                && (cfg_i.master || !ncs_s);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      txe_ff  <= SEFB_TXE_RST;
      hold_ff <= '0;
    end else if (soft_reset_bit_i) begin
      txe_ff  <= SEFB_TXE_RST;
    end else if (wr_ok) begin
      txe_ff  <= 1'b0;
      hold_ff <= tx_data_reg_i;
    end else if (load) begin
      txe_ff  <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Bit clock divider
  // ----------------------------------------------------------------
  logic [7:0] div_ff;
  logic       tick;
  assign tick = (div_ff == 8'h00);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_ff <= SEFB_DIV_RST;
    end else if (st_ff != SEFB_SHIFT || tick) begin
      div_ff <= (clk_div_i == 8'h00) ? 8'h00 : clk_div_i - 8'h01;
    end else begin
      div_ff <= div_ff - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Shifter; slave mode samples on synchronised sck edges
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] sh_ff;
  logic [3:0]        cnt_ff;
  logic              sck_ff, sck_d_ff, phase_ff;
  logic              s_lead, s_trail, lead, trail;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sck_d_ff <= 1'b0;
    end else begin
      sck_d_ff <= sck_s;
    end
  end
  assign s_lead  = (sck_s != sck_d_ff) && (sck_s != cfg_i.cpol);
  assign s_trail = (sck_s != sck_d_ff) && (sck_s == cfg_i.cpol);
  assign lead    = cfg_i.master ? (tick && !phase_ff) : s_lead;
  assign trail   = cfg_i.master ? (tick && phase_ff) : s_trail;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff    <= SEFB_IDLE;
      sh_ff    <= '0;
      cnt_ff   <= 4'h0;
      phase_ff <= 1'b0;
      sck_ff   <= 1'b0;
    end else if (soft_reset_bit_i) begin
      st_ff    <= SEFB_IDLE;
      phase_ff <= 1'b0;
      sck_ff   <= cfg_i.cpol;
    end else begin
      case (st_ff)
        SEFB_IDLE: begin
          sck_ff <= cfg_i.cpol;
          if (load) begin
            sh_ff    <= hold_ff;
            cnt_ff   <= 4'(DATA_W);
            phase_ff <= 1'b0;
            st_ff    <= SEFB_SHIFT;
          end
        end
        SEFB_SHIFT: begin
          if (cfg_i.master ? !en_ff : ncs_s) begin
            // A cut frame ends here, so sck never runs on with ncs0 released
            st_ff    <= SEFB_IDLE;
            phase_ff <= 1'b0;
            sck_ff   <= cfg_i.cpol;
          end else if (lead) begin
            sck_ff   <= ~cfg_i.cpol;
            phase_ff <= 1'b1;
            sh_ff    <= {sh_ff[DATA_W-2:0], cfg_i.master ? miso_s : mosi_s};
            cnt_ff   <= cnt_ff - 4'h1;
          end else if (trail) begin
            sck_ff   <= cfg_i.cpol;
            phase_ff <= 1'b0;
            if (cnt_ff == 4'h0) begin
              st_ff <= SEFB_DONE;
            end
          end
        end
        SEFB_DONE: begin
          st_ff <= SEFB_IDLE;
        end
        default: begin
          st_ff <= SEFB_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive register and outputs
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rx_ff;
  logic              rxf_ff, mosi_ff, ncs_ff;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_ff  <= '0;
      rxf_ff <= 1'b0;
    end else if (soft_reset_bit_i) begin
      rxf_ff <= 1'b0;
    end else if (st_ff == SEFB_DONE) begin
      rx_ff  <= sh_ff;
      rxf_ff <= 1'b1; // Completion wins over a same-cycle read
    end else if (rx_rd_i) begin
      rxf_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mosi_ff <= 1'b0;
      ncs_ff  <= 1'b1;
    end else begin
      mosi_ff <= (st_ff == SEFB_IDLE && load) ? hold_ff[DATA_W-1] : sh_ff[DATA_W-1];
      if (!cfg_i.master || !en_ff) begin
        ncs_ff <= 1'b1;
      end else if (load) begin
        ncs_ff <= 1'b0;
      end else if (st_ff == SEFB_DONE && !cfg_i.cs_hold_after_transfer) begin
        ncs_ff <= 1'b1;
      end
    end
  end

  logic oe_n_ff;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      oe_n_ff <= 1'b1;
    end else begin
      oe_n_ff <= !(en_ff && !cfg_i.master && !ncs_s);
    end
  end

  assign enabled_o       = en_ff;
  assign tx_empty_flag_o = txe_ff;
  assign rx_full_o       = rxf_ff;
  assign rx_data_o       = rx_ff;
  assign busy_o          = phase_ff;
  assign sck_o           = sck_ff;
  assign mosi_o          = mosi_ff;
  assign miso_o          = mosi_ff;
  assign miso_oe_n_o     = oe_n_ff;
  assign ncs0_o          = ncs_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  chk_fault_no_start: assert property (
    fault_block && st_ff == SEFB_IDLE |=> st_ff == SEFB_IDLE)
    else $error("transfer started under mode fault hold");
  chk_slave_keeps_en: assert property (
    en_ff && !cfg_i.master && disable_cmd_i && !soft_reset_bit_i |=> en_ff)
    else $error("slave stopped by disable");
  chk_softrst_stops: assert property (
    soft_reset_bit_i |=> !en_ff && txe_ff && st_ff == SEFB_IDLE)
    else $error("soft reset did not stop controller");
  chk_dis_write_drop: assert property (
    !en_ff && !soft_reset_bit_i |=> txe_ff == $past(txe_ff) && hold_ff == $past(hold_ff))
    else $error("write accepted while disabled");
  chk_txe_not_cleared: assert property (
    txe_ff && tx_wr_i && !en_ff |=> txe_ff) else $error("empty flag cleared while disabled");
  chk_dma_late_drop: assert property (
    $past(en_ff, 4) && !en_ff && tx_wr_i |=> $stable(hold_ff) && $stable(txe_ff))
    else $error("late dma word stored");
  chk_write_clears: assert property (
    en_ff && tx_wr_i && !soft_reset_bit_i |=> !txe_ff) else $error("enabled write lost");
  chk_done_rx: assert property (
    st_ff == SEFB_DONE && !soft_reset_bit_i |=> rxf_ff && rx_ff == $past(sh_ff))
    else $error("received word not captured");

  cov_master_xfer: cover property (cfg_i.master && st_ff == SEFB_DONE);
  cov_slave_xfer:  cover property (!cfg_i.master && st_ff == SEFB_DONE);
  cov_fault_hold:  cover property (fault_block && !txe_ff && en_ff);
  cov_dis_write:   cover property (!en_ff && tx_wr_i && txe_ff);
endmodule : sefb_spi

/* logic/sefb_sync.sv */
// Three-stage input synchroniser for SPI pins.
// Assumes the pin is asynchronous to clk_i; output changes when stages two and three agree.
`timescale 1ns/1ps
module sefb_sync (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic pin_i,
  input  wire logic rst_val_i,
  output logic      level_o
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Filtered level; rst_val_i holds until stages two and three carry real pin samples,
  // otherwise the cleared stages would agree on zero and fake a pin edge after reset
  logic       lvl_ff;
  logic [1:0] init_ff;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lvl_ff  <= 1'b0;
      init_ff <= 2'h0;
    end else if (init_ff != 2'h3) begin
      lvl_ff  <= rst_val_i;
      init_ff <= init_ff + 2'h1;
    end else if (s2_ff == s3_ff) begin
      lvl_ff <= s3_ff;
    end
  end
  assign level_o = lvl_ff;
endmodule : sefb_sync

/* verif/sefb_spi_dev.sv */
// External SPI slave that faces the controller while it runs in master role.
// Assumes mode 0 timing: sample on the rising sck edge, shift out on the falling edge.
`timescale 1ns/1ps
module sefb_spi_dev #(
  parameter logic [7:0] REPLY = 8'h3C
) (
  input  wire logic  sck_i,
  input  wire logic  ncs_i,
  input  wire logic  mosi_i,
  output logic       miso_o,
  output logic [7:0] rx_o,
  output int         count_o
);
  logic [7:0] shift_q;
  int         bits_q;

  initial begin
    miso_o  = 1'b0;
    rx_o    = 8'h00;
    count_o = 0;
    bits_q  = 0;
    shift_q = REPLY;
  end
  always @(negedge ncs_i) begin
    shift_q = REPLY;
    bits_q  = 0;
    miso_o  = REPLY[7];
  end
  always @(posedge sck_i) begin
    if (!ncs_i) begin
      rx_o   = {rx_o[6:0], mosi_i};
      bits_q = bits_q + 1;
      if (bits_q == 8) begin
        count_o = count_o + 1;
        bits_q  = 0;
        shift_q = REPLY;
      end
    end
  end
  always @(negedge sck_i) begin
    if (!ncs_i && bits_q != 0) begin
      shift_q = {shift_q[6:0], 1'b0};
      miso_o  = shift_q[7];
    end
  end
  // Released line: no stable level, so the last value is inverted
  always @(posedge ncs_i) begin
    miso_o = ~miso_o;
  end
endmodule : sefb_spi_dev

/* verif/spi_enable_fault_behaviour_tb_top.sv */
// Self-checking bench for the SPI controller enable, disable and mode-fault behaviour.
// Assumes the design package is compiled first; one 50 MHz clock, active-low reset.
`timescale 1ns/1ps
module spi_enable_fault_behaviour_tb_top;
  import sefb_pkg::*;
  logic clk_i = 1'b0, reset_n_i = 1'b0, en_c = 1'b0, dis_c = 1'b0, srst = 1'b0;
  logic tx_wr = 1'b0, rx_rd = 1'b0, mosi_s = 1'b0, sck_s = 1'b0, ncs_s = 1'b1;
  logic [7:0] txd = 8'h00, div = 8'h08, rxd, dev_rx;
  sefb_cfg_t  cfg = '{1'b1, 1'b0, 1'b0, 1'b0};
  logic enabled, txe, rxf, busy, sck, mosi, miso_dev, ncs0, miso_pin, miso_oen;
  logic [7:0] miso_cap = 8'h00;
  logic       oen_cap  = 1'b0;
  int   fails = 0, num_checks = 0, dev_cnt, n0;

  always #10 clk_i = ~clk_i;

  sefb_spi i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .cfg_i(cfg), .clk_div_i(div),
    .enable_cmd_i(en_c), .disable_cmd_i(dis_c), .soft_reset_bit_i(srst), .tx_wr_i(tx_wr),
    .tx_data_reg_i(txd), .rx_rd_i(rx_rd), .miso_i(miso_dev), .mosi_i(mosi_s),
    .sck_i(sck_s), .ncs_i(ncs_s), .enabled_o(enabled), .tx_empty_flag_o(txe),
    .rx_full_o(rxf), .rx_data_o(rxd), .busy_o(busy), .sck_o(sck), .mosi_o(mosi),
    .miso_o(miso_pin), .miso_oe_n_o(miso_oen), .ncs0_o(ncs0));
  sefb_spi_dev i_dev (.sck_i(sck), .ncs_i(ncs0), .mosi_i(mosi), .miso_o(miso_dev),
    .rx_o(dev_rx), .count_o(dev_cnt));

  task automatic final_report;
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Commands and writes are one-cycle pulses launched just after an edge
  task automatic pulse(input int sel);
    @(posedge clk_i);
    case (sel)
      0: en_c <= 1'b1;
      1: dis_c <= 1'b1;
      2: srst <= 1'b1;
      default: rx_rd <= 1'b1;
    endcase
    @(posedge clk_i);
    {en_c, dis_c, srst, rx_rd} <= 4'h0;
  endtask : pulse

  task automatic wr(input logic [7:0] d);
    @(posedge clk_i);
    tx_wr <= 1'b1;
    txd   <= d;
    @(posedge clk_i);
    tx_wr <= 1'b0;
  endtask : wr

  task automatic wait_rx;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk_i);
      if (rxf === 1'b1) return;
    end
    fails++;
    $display("FAIL rx_full timeout expected 1 seen %b", rxf);
    final_report();
  endtask : wait_rx

  // Drives the controller's slave pins as an external master would
  task automatic slave_xfer(input logic [7:0] d);
    @(posedge clk_i) ncs_s <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi_s <= d[i];
      repeat (8) @(posedge clk_i);
      miso_cap = {miso_cap[6:0], miso_pin};
      oen_cap  = oen_cap | miso_oen;
      sck_s <= 1'b1;
      repeat (8) @(posedge clk_i);
      sck_s <= 1'b0;
    end
    repeat (8) @(posedge clk_i);
    ncs_s  <= 1'b1;
    mosi_s <= ~mosi_s;
  endtask : slave_xfer

  initial begin
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("txe_reset", 8'(SEFB_TXE_RST), 8'(txe));
    wr(8'h11);
    repeat (20) @(posedge clk_i);
    chk("txe_wr_disabled", 8'h01, 8'(txe));
    chk("busy_wr_disabled", 8'h00, 8'(busy));
    pulse(0);
    wr(8'hA5);
    wait_rx();
    chk("master_rx", 8'h3C, rxd);
    chk("dev_rx", 8'hA5, dev_rx);
    pulse(3);
    wr(8'h5A);
    for (int i = 0; i < 8; i++) @(posedge clk_i);
    n0 = dev_cnt;
    repeat (2) @(posedge clk_i);
    pulse(1);
    for (int i = 0; i < 3; i++) begin
      wr(8'hF0 + 8'(i));
      chk("txe_dma_drop", 8'h01, 8'(txe));
    end
    repeat (800) @(posedge clk_i);
    chk("busy_after_disable", 8'h00, 8'(busy));
    chk("words_after_disable", 8'h01, 8'(dev_cnt <= n0 + 1));
    pulse(3);
    pulse(0);
    wr(8'hC3);
    wait_rx();
    chk("dev_rx_resume", 8'hC3, dev_rx);
    pulse(3);
    @(posedge clk_i) cfg <= '{1'b1, 1'b1, 1'b0, 1'b0};
    n0 = dev_cnt;
    wr(8'h69);
    repeat (300) @(posedge clk_i);
    chk("txe_fault_block", 8'h00, 8'(txe));
    chk("ncs0_fault_block", 8'h01, 8'(ncs0));
    chk("no_words_blocked", 8'(n0), 8'(dev_cnt));
    @(posedge clk_i) cfg <= '{1'b1, 1'b1, 1'b1, 1'b0};
    wait_rx();
    chk("dev_rx_held_cs", 8'h69, dev_rx);
    repeat (4) @(posedge clk_i);
    chk("ncs0_held", 8'h00, 8'(ncs0));
    pulse(3);
    @(posedge clk_i) cfg <= '{1'b0, 1'b0, 1'b0, 1'b0};
    pulse(1);
    repeat (4) @(posedge clk_i);
    chk("slave_still_enabled", 8'h01, 8'(enabled));
    wr(8'h4B);
    slave_xfer(8'h96);
    wait_rx();
    chk("slave_rx", 8'h96, rxd);
    chk("slave_miso", 8'h4B, miso_cap);
    chk("slave_oe_n", 8'h00, 8'(oen_cap));
    pulse(3);
    pulse(2);
    repeat (2) @(posedge clk_i);
    chk("enabled_after_srst", 8'h00, 8'(enabled));
    chk("txe_after_srst", 8'h01, 8'(txe));
    chk("rxf_after_srst", 8'h00, 8'(rxf));
    final_report();
  end
endmodule : spi_enable_fault_behaviour_tb_top
